// file: anlts_pkg.sv
package anlts_pkg;
	// -------------------------------------------------------------
	// link timer
	// -------------------------------------------------------------
	localparam int TIMER_W = 9;
	localparam int TICK_CYCLES = 4096;
	localparam int TICK_W = 12;
	localparam logic [TIMER_W-1:0] TIMER_RST = 9'h000;

	// -------------------------------------------------------------
	// standards and timer states
	// -------------------------------------------------------------
	typedef enum logic {
		ANLTS_BASEX,
		ANLTS_SGMII
	} anlts_std_e;

	typedef enum logic {
		ANLTS_IDLE,
		ANLTS_RUN
	} anlts_tmr_e;

	// -------------------------------------------------------------
	// avalon register map of the management controller (word index)
	// -------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] REG_TIMER = 3'h0;
	localparam logic [ADDR_W-1:0] REG_TIMERS_DYN = 3'h1;
	localparam logic [ADDR_W-1:0] REG_STRAP = 3'h2;
	localparam logic [ADDR_W-1:0] REG_COMMAND = 3'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;

	// field positions
	localparam int SGMII_LSB = 16;
	localparam int CMD_IRQ_EN = 0;
	localparam int CMD_IRQ_CLR = 1;
	localparam int CMD_STD = 2;
	localparam int CMD_STD_WR = 3;
	localparam int CMD_RESTART = 4;
	localparam int ST_IRQ = 0;
	localparam int ST_STD = 1;
	localparam int ST_BUSY = 2;

	// reset values
	localparam logic [31:0] TIMERS_DYN_RST = 32'h0000_0000;
	localparam logic STRAP_RST = 1'b0;
endpackage : anlts_pkg

// file: anlts_if.sv
`timescale 1ns/1ps
interface anlts_if;
	logic [anlts_pkg::TIMER_W-1:0] link_timer_value;
	logic [anlts_pkg::TIMER_W-1:0] link_timer_basex;
	logic [anlts_pkg::TIMER_W-1:0] link_timer_sgmii;
	logic std_strap;
	logic cmd_valid;
	logic cmd_irq_enable;
	logic cmd_irq_clear;
	logic cmd_std_write;
	logic cmd_std;
	logic cmd_restart;
	logic autoneg_done_irq;
	logic std_active;
	logic timer_busy;

	modport dev (
		input link_timer_value,
		input link_timer_basex,
		input link_timer_sgmii,
		input std_strap,
		input cmd_valid,
		input cmd_irq_enable,
		input cmd_irq_clear,
		input cmd_std_write,
		input cmd_std,
		input cmd_restart,
		output autoneg_done_irq,
		output std_active,
		output timer_busy
	);

	modport mgr (
		output link_timer_value,
		output link_timer_basex,
		output link_timer_sgmii,
		output std_strap,
		output cmd_valid,
		output cmd_irq_enable,
		output cmd_irq_clear,
		output cmd_std_write,
		output cmd_std,
		output cmd_restart,
		input autoneg_done_irq,
		input std_active,
		input timer_busy
	);
endinterface : anlts_if

// file: anlts_dev.sv
// Behaviour
// (RQ1) timer period is setting times 4096 clocks
// (RQ2) timer settings held constant by integrator
// (RQ3) dynamic mode uses two per-standard settings
// (RQ4) 1000BASE-X uses its own setting times 4096
// (RQ5) SGMII uses its own setting times 4096
// (RQ6) active-high interrupt on negotiation completion
// (RQ7) interrupt enabled, disabled, cleared by management
// (RQ8) strap picks standard leaving reset
// (RQ9) management writes may change standard later
// (RQ10) dynamic mode always keeps management port
// (RQ11) all signals synchronous to core clock
// (RQ12) timer restarts from zero, flags expiry
`timescale 1ns/1ps
module anlts_dev #(
	parameter bit DYN_SWITCH = 1'b1,
	parameter int TICK_CYCLES = anlts_pkg::TICK_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	anlts_if.dev link,
	output logic expiry_out,
	output logic std_sgmii_out
);
	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	localparam int TW = anlts_pkg::TIMER_W;
	localparam int KW = anlts_pkg::TICK_W;
	localparam logic [KW-1:0] TICK_LAST = KW'(TICK_CYCLES - 1);

	anlts_pkg::anlts_tmr_e state;
	anlts_pkg::anlts_tmr_e next_state;
	logic [KW-1:0] tick;
	logic [KW-1:0] next_tick;
	logic [TW-1:0] units;
	logic [TW-1:0] next_units;
	logic [TW-1:0] period;
	logic [TW-1:0] next_period;
	logic expire;
	logic next_expire;

	anlts_pkg::anlts_std_e std;
	anlts_pkg::anlts_std_e next_std;
	logic strap_taken;
	logic next_strap_taken;

	logic irq_pending;
	logic next_irq_pending;
	logic irq_enable;
	logic next_irq_enable;
	logic irq_out;
	logic next_irq_out;

	logic [TW-1:0] setting;
	logic restart;

	// -------------------------------------------------------------
	// timer setting selection
	// -------------------------------------------------------------
	// the settings are sampled only at restart, so a setting that
	// moves mid-interval cannot shorten the running one
	always_comb
	begin
		if (DYN_SWITCH)
		begin
			// the single setting is not used in dynamic mode
			if (std == anlts_pkg::ANLTS_SGMII)
				setting = link.link_timer_sgmii; // see RQ5 see RQ3
			else
				setting = link.link_timer_basex; // see RQ4 see RQ3
		end
		else
		begin
			setting = link.link_timer_value; // see RQ1 see RQ2
		end
	end

	// commands arrive from logic on this same clock: no sync needed
	assign restart = link.cmd_valid & link.cmd_restart; // see RQ11

	// -------------------------------------------------------------
	// link timer
	// -------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_tick = tick;
		next_units = units;
		next_period = period;
		next_expire = 1'b0;
		unique case (state)
			anlts_pkg::ANLTS_IDLE:
			begin
				if (restart)
				begin
					next_state = anlts_pkg::ANLTS_RUN;
					next_tick = '0; // see RQ12
					next_units = '0;
					next_period = setting;
				end
			end
			anlts_pkg::ANLTS_RUN:
			begin
				if (restart)
				begin
					// a new interval throws away the old count
					next_tick = '0; // see RQ12
					next_units = '0;
					next_period = setting;
				end
				else if (period == anlts_pkg::TIMER_RST)
				begin
					// a zero setting expires at once
					next_state = anlts_pkg::ANLTS_IDLE;
					next_expire = 1'b1;
				end
				else if (tick == TICK_LAST)
				begin
					// one unit is TICK_CYCLES clocks
					next_tick = '0; // see RQ1
					next_units = units + 1'b1;
					if (units + 1'b1 == period)
					begin
						next_state = anlts_pkg::ANLTS_IDLE;
						next_expire = 1'b1; // see RQ12
					end
				end
				else
				begin
					next_tick = tick + 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state <= anlts_pkg::ANLTS_IDLE;
			tick <= '0;
			units <= '0;
			period <= anlts_pkg::TIMER_RST;
			expire <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tick <= next_tick;
			units <= next_units;
			period <= next_period;
			expire <= next_expire;
		end
	end

	// -------------------------------------------------------------
	// standard selection
	// -------------------------------------------------------------
	// the strap is caught at the first edge after release, never
	// loaded under the asynchronous reset itself
	always_comb
	begin
		next_std = std;
		next_strap_taken = 1'b1;
		if (!strap_taken)
		begin
			if (link.std_strap)
				next_std = anlts_pkg::ANLTS_SGMII; // see RQ8
			else
				next_std = anlts_pkg::ANLTS_BASEX; // see RQ8
		end
		else if (DYN_SWITCH && link.cmd_valid && link.cmd_std_write)
		begin
			// in dynamic mode the management port is live once the strap is taken; the strap wins at the first edge
			if (link.cmd_std)
				next_std = anlts_pkg::ANLTS_SGMII; // see RQ9 see RQ10
			else
				next_std = anlts_pkg::ANLTS_BASEX; // see RQ9 see RQ10
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			std <= anlts_pkg::ANLTS_BASEX;
			strap_taken <= 1'b0;
		end
		else
		begin
			std <= next_std;
			strap_taken <= next_strap_taken;
		end
	end

	// -------------------------------------------------------------
	// completion interrupt
	// -------------------------------------------------------------
	always_comb
	begin
		next_irq_pending = irq_pending;
		next_irq_enable = irq_enable;
		if (link.cmd_valid)
		begin
			next_irq_enable = link.cmd_irq_enable; // see RQ7
			if (link.cmd_irq_clear)
				next_irq_pending = 1'b0; // see RQ7
		end
		// a completion in the clearing cycle is kept
		if (expire)
			next_irq_pending = 1'b1; // see RQ6
		next_irq_out = next_irq_pending & next_irq_enable; // see RQ6
	end

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			irq_pending <= 1'b0;
			irq_enable <= 1'b0;
			irq_out <= 1'b0;
		end
		else
		begin
			irq_pending <= next_irq_pending;
			irq_enable <= next_irq_enable;
			irq_out <= next_irq_out;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign link.autoneg_done_irq = irq_out;
	assign link.std_active = (std == anlts_pkg::ANLTS_SGMII);
	assign link.timer_busy = (state == anlts_pkg::ANLTS_RUN);
	assign expiry_out = expire;
	assign std_sgmii_out = (std == anlts_pkg::ANLTS_SGMII);
endmodule : anlts_dev

// file: anlts_mgr.sv
`timescale 1ns/1ps
module anlts_mgr (
	input wire logic mclk_in,
	input wire logic rstn_in,
	anlts_if.mgr link,
	input wire logic [anlts_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);
	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	localparam int TW = anlts_pkg::TIMER_W;

	logic wait_q;
	logic next_wait_q;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [31:0] timer_reg;
	logic [31:0] next_timer_reg;
	logic [31:0] dyn_reg;
	logic [31:0] next_dyn_reg;
	logic strap;
	logic next_strap;
	logic [4:0] cmd;
	logic [4:0] next_cmd;
	logic cmd_valid;
	logic next_cmd_valid;
	logic [31:0] mask;
	logic do_write;

	// -------------------------------------------------------------
	// avalon slave: one wait state on every access
	// -------------------------------------------------------------
	assign do_write = avs_write_in & ~wait_q;
	assign mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

	always_comb
	begin
		next_wait_q = 1'b1;
		next_rdata = rdata;
		next_timer_reg = timer_reg;
		next_dyn_reg = dyn_reg;
		next_strap = strap;
		next_cmd = cmd;
		next_cmd_valid = 1'b0;
		if ((avs_read_in | avs_write_in) & wait_q)
			next_wait_q = 1'b0;
		if (avs_read_in & wait_q)
		begin
			unique case (avs_address_in)
				anlts_pkg::REG_TIMER: next_rdata = timer_reg;
				anlts_pkg::REG_TIMERS_DYN: next_rdata = dyn_reg;
				anlts_pkg::REG_STRAP: next_rdata = {31'h0, strap};
				anlts_pkg::REG_COMMAND: next_rdata = {27'h0, cmd};
				anlts_pkg::REG_STATUS:
				begin
					next_rdata = 32'h0;
					next_rdata[anlts_pkg::ST_IRQ] = link.autoneg_done_irq;
					next_rdata[anlts_pkg::ST_STD] = link.std_active;
					next_rdata[anlts_pkg::ST_BUSY] = link.timer_busy;
				end
				default: next_rdata = 32'h0;
			endcase
		end
		if (do_write)
		begin
			unique case (avs_address_in)
				anlts_pkg::REG_TIMER:
					next_timer_reg = (timer_reg & ~mask) |
						(avs_writedata_in & mask & 32'h0000_01ff);
				anlts_pkg::REG_TIMERS_DYN:
					next_dyn_reg = (dyn_reg & ~mask) |
						(avs_writedata_in & mask & 32'h01ff_01ff);
				anlts_pkg::REG_STRAP:
					if (avs_byteenable_in[0])
						next_strap = avs_writedata_in[0];
				anlts_pkg::REG_COMMAND:
					// each write with byte 0 enabled is one command to the device
					if (avs_byteenable_in[0])
					begin
						next_cmd = avs_writedata_in[4:0];
						next_cmd_valid = 1'b1;
					end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wait_q <= 1'b1;
			rdata <= 32'h0;
			timer_reg <= 32'h0;
			dyn_reg <= anlts_pkg::TIMERS_DYN_RST;
			strap <= anlts_pkg::STRAP_RST;
			cmd <= 5'h00;
			cmd_valid <= 1'b0;
		end
		else
		begin
			wait_q <= next_wait_q;
			rdata <= next_rdata;
			timer_reg <= next_timer_reg;
			dyn_reg <= next_dyn_reg;
			strap <= next_strap;
			cmd <= next_cmd;
			cmd_valid <= next_cmd_valid;
		end
	end

	// -------------------------------------------------------------
	// link drive
	// -------------------------------------------------------------
	// settings stay steady between software writes
	assign link.link_timer_value = timer_reg[TW-1:0]; // see RQ2
	assign link.link_timer_basex = dyn_reg[TW-1:0]; // see RQ2
	assign link.link_timer_sgmii =
		dyn_reg[anlts_pkg::SGMII_LSB +: TW]; // see RQ2
	assign link.std_strap = strap;
	// the irq enable and clear travel only through this port
	assign link.cmd_valid = cmd_valid; // see RQ7 see RQ9
	assign link.cmd_irq_enable = cmd[anlts_pkg::CMD_IRQ_EN];
	assign link.cmd_irq_clear = cmd[anlts_pkg::CMD_IRQ_CLR];
	assign link.cmd_std_write = cmd[anlts_pkg::CMD_STD_WR];
	assign link.cmd_std = cmd[anlts_pkg::CMD_STD];
	assign link.cmd_restart = cmd[anlts_pkg::CMD_RESTART];
	assign avs_readdata_out = rdata;
	assign avs_waitrequest_out = wait_q;
endmodule : anlts_mgr

// file: anlts_checker.sv
`timescale 1ns/1ps
module anlts_checker #(
	parameter int TICK_CYCLES = anlts_pkg::TICK_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [8:0] link_timer_basex,
	input wire logic [8:0] link_timer_sgmii,
	input wire logic std_strap,
	input wire logic cmd_valid,
	input wire logic cmd_irq_enable,
	input wire logic cmd_irq_clear,
	input wire logic cmd_std_write,
	input wire logic cmd_std,
	input wire logic cmd_restart,
	input wire logic autoneg_done_irq,
	input wire logic std_active,
	input wire logic timer_busy
);
	// ----------------------------------
	// expected interval length
	// ----------------------------------
	int cnt;
	int per;
	int next_cnt;
	int next_per;
	logic run;
	logic next_run;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	always_comb
	begin
		next_cnt = cnt;
		next_per = per;
		next_run = run;
		if (cmd_valid && cmd_restart)
		begin
			next_run = 1'b1;
			next_cnt = 1;
			next_per = int'(std_active ? link_timer_sgmii : link_timer_basex);
			next_per = next_per * TICK_CYCLES;
			// a zero setting still expires one cycle later
			if (next_per == 0)
				next_per = 1;
		end
		else if (run && cnt <= per)
			next_cnt = cnt + 1;
	end
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt <= 0;
			per <= 0;
			run <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			per <= next_per;
			run <= next_run;
		end
	end
	property p_period;
		run && cnt <= per + 1 |-> timer_busy == (cnt <= per);
	endproperty
	a_period: assert property (p_period)
		else $error("timer interval length wrong");
	property p_start;
		cmd_valid && cmd_restart |=> timer_busy;
	endproperty
	a_start: assert property (p_start)
		else $error("timer did not start");
	property p_strap;
		rstn_in && !$past(rstn_in) |=> std_active == std_strap;
	endproperty
	a_strap: assert property (p_strap)
		else $error("standard after reset wrong");
	property p_std_cmd;
		cmd_valid && cmd_std_write |=> std_active == $past(cmd_std);
	endproperty
	a_std_cmd: assert property (p_std_cmd)
		else $error("standard write ignored");
	property p_irq_off;
		cmd_valid && !cmd_irq_enable |=> !autoneg_done_irq;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("disabled interrupt raised");
	property p_irq_clr;
		cmd_valid && cmd_irq_clear && !timer_busy && !$past(timer_busy)
			|=> !autoneg_done_irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr)
		else $error("interrupt not cleared");
	property p_irq_src;
		$rose(autoneg_done_irq) |->
			$past(timer_busy, 2) || ($past(cmd_valid) && $past(cmd_irq_enable));
	endproperty
	a_irq_src: assert property (p_irq_src)
		else $error("interrupt without completion");
	property p_cmd_pulse;
		cmd_valid |=> !cmd_valid;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse)
		else $error("command strobe too long");
endmodule : anlts_checker

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	// ----------------------------------
	// harness
	// ----------------------------------
	localparam int TK = 4;
	logic mclk_in = 1'b0;
	logic rstn = 1'b0;
	logic rstn_dev = 1'b0;
	logic [2:0] adr = 3'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic wreq;
	logic expiry;
	logic std_sgmii;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	int len;
	int tb[4][4] = '{'{0,3,5,12}, '{1,3,5,20}, '{0,0,7,1}, '{1,2,511,2044}};
	anlts_if link();
	anlts_dev #(.TICK_CYCLES(TK)) u_anlts_dev (.mclk_in(mclk_in),
		.rstn_in(rstn_dev), .link(link), .expiry_out(expiry),
		.std_sgmii_out(std_sgmii));
	anlts_mgr u_anlts_mgr (.mclk_in(mclk_in), .rstn_in(rstn), .link(link),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wreq));
	anlts_checker #(.TICK_CYCLES(TK)) u_anlts_checker (.mclk_in(mclk_in),
		.rstn_in(rstn_dev), .link_timer_basex(link.link_timer_basex),
		.link_timer_sgmii(link.link_timer_sgmii), .std_strap(link.std_strap),
		.cmd_valid(link.cmd_valid), .cmd_irq_enable(link.cmd_irq_enable),
		.cmd_irq_clear(link.cmd_irq_clear), .cmd_std(link.cmd_std),
		.cmd_std_write(link.cmd_std_write), .cmd_restart(link.cmd_restart),
		.autoneg_done_irq(link.autoneg_done_irq),
		.std_active(link.std_active), .timer_busy(link.timer_busy));
	initial
	begin
		forever #10 mclk_in = ~mclk_in;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	always @(posedge mclk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// read data is taken at the very edge that samples waitrequest low
	task automatic bus(input int w, input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		adr <= a;
		wr <= (w != 0);
		rd <= (w == 0);
		wdat <= d;
		do
		begin
			@(posedge mclk_in);
		end while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic run_timer();
		int n;
		n = 0;
		len = 0;
		while (link.timer_busy !== 1'b1 && n < 10)
		begin
			@(negedge mclk_in);
			n++;
		end
		while (link.timer_busy === 1'b1)
		begin
			@(negedge mclk_in);
			len++;
		end
		chk(32'(expiry), 32'h1);
	endtask : run_timer
	initial
	begin
		repeat (3) @(posedge mclk_in);
		rstn <= 1'b1;
		rstn_dev <= 1'b1;
		bus(0, anlts_pkg::REG_TIMERS_DYN, 0);
		chk(q, anlts_pkg::TIMERS_DYN_RST);
		bus(0, anlts_pkg::REG_STATUS, 0);
		chk(q, 0);
		bus(1, 3'h5, 32'hffff_ffff);
		bus(0, 3'h5, 0);
		chk(q, 0);
		bus(1, anlts_pkg::REG_TIMER, 32'hffff_ffff);
		bus(0, anlts_pkg::REG_TIMER, 0);
		chk(q, 32'h0000_01ff);
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			bus(1, anlts_pkg::REG_TIMERS_DYN,
				{7'h0, 9'(tb[i][2]), 7'h0, 9'(tb[i][1])});
			bus(1, anlts_pkg::REG_COMMAND, {29'h1, 1'(tb[i][0]), 2'b01});
			bus(1, anlts_pkg::REG_COMMAND, 32'h11);
			run_timer();
			chk(len, tb[i][3]);
			bus(0, anlts_pkg::REG_STATUS, 0);
			chk(q, {30'h0, 1'(tb[i][0]), 1'b1});
			bus(1, anlts_pkg::REG_COMMAND, 32'h03);
			repeat (2) @(negedge mclk_in);
			chk(32'(link.autoneg_done_irq), 32'h0);
		end
		$display("table test done");
		bus(1, anlts_pkg::REG_TIMERS_DYN, 32'h0001_0001);
		bus(1, anlts_pkg::REG_COMMAND, 32'h10);
		bus(1, anlts_pkg::REG_COMMAND, 32'h10);
		// the second restart lands one cycle after the call returns,
		// so busy stands one interval plus two cycles from here
		run_timer();
		chk(len, TK + 2);
		chk(32'(link.autoneg_done_irq), 32'h0);
		bus(1, anlts_pkg::REG_COMMAND, 32'h01);
		repeat (2) @(negedge mclk_in);
		chk(32'(link.autoneg_done_irq), 32'h1);
		$display("mask test done");
		bus(1, anlts_pkg::REG_STRAP, 1);
		@(posedge mclk_in);
		rstn_dev <= 1'b0;
		repeat (3) @(posedge mclk_in);
		rstn_dev <= 1'b1;
		repeat (2) @(negedge mclk_in);
		chk({30'h0, std_sgmii, link.std_active}, 32'h3);
		bus(1, anlts_pkg::REG_COMMAND, 32'h09);
		repeat (2) @(negedge mclk_in);
		chk({30'h0, std_sgmii, link.std_active}, 32'h0);
		$display("strap test done");
		final_report();
	end
endmodule : testbench
